// [isr_pkg.sv]
package isr_pkg;
   // register word indices on the avalon slave
   localparam logic [2:0] REG_CTRL   = 3'h0;
   localparam logic [2:0] REG_EXPO   = 3'h1;
   localparam logic [2:0] REG_GAIN   = 3'h2;
   localparam logic [2:0] REG_BLACK  = 3'h3;
   localparam logic [2:0] REG_STATUS = 3'h4;
   // control register fields
   localparam int CTL_EN   = 0;
   localparam int CTL_PAR  = 1;
   localparam int CTL_CMP  = 2;
   localparam int CTL_MODE = 4;
   localparam int CTL_VCM  = 9;
   // reset values: full frame, serial feed, streaming
   localparam logic [9:0]  CTRL_RST  = 10'h001;
   localparam logic [10:0] EXPO_RST  = 11'h200;
   localparam logic [7:0]  GAIN_RST  = 8'h10;
   localparam logic [11:0] BLACK_RST = 12'h0a8;
   // digital gain is 4.4 fixed point
   localparam int GAIN_FRAC = 4;
   localparam logic [11:0] PIX_MAX = 12'hfff;
   // output rates and master clock range
   localparam int RATE_FULL_MPS = 196;
   localparam int RATE_HALF_MPS = 98;
   localparam int MCLK_MIN_MHZ  = 6;
   localparam int MCLK_MAX_MHZ  = 27;
   localparam int FPS_DEFAULT   = 60;
   // geometry of the readout windows
   localparam logic [11:0] FULL_W     = 12'h900;
   localparam logic [11:0] FULL_H     = 12'h510;
   localparam logic [11:0] SUB3_WIN_W = 12'h8d0;
   localparam logic [11:0] SUB3_WIN_H = 12'h5a0;
   localparam logic [11:0] HBLANK     = 12'h040;
   localparam logic [11:0] VBLANK     = 12'h010;
   // companding segment bounds and code bases
   localparam logic [11:0] SEG1      = 12'h100;
   localparam logic [11:0] SEG2      = 12'h200;
   localparam logic [11:0] SEG3      = 12'h800;
   localparam logic [9:0]  SEG1_BASE = 10'h100;
   localparam logic [9:0]  SEG2_BASE = 10'h180;
   localparam logic [9:0]  SEG3_BASE = 10'h300;

   typedef logic [11:0] isr_pix_t;
   typedef logic [11:0] isr_row_t;
   typedef enum logic [1:0] {MODE_FULL = 2'b00, MODE_SUB2 = 2'b01, MODE_SUB3 = 2'b10} isr_mode_e;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01} isr_state_e;
   typedef struct packed {
      logic [1:0]  mode;
      logic        compand;
      logic        parallel;
      logic        enable;
      logic [10:0] expo;
      logic [7:0]  gain;
      logic [11:0] black;
   } isr_cfg_s;
   localparam isr_cfg_s CFG_RST = {CTRL_RST[5:4], CTRL_RST[2], CTRL_RST[1], CTRL_RST[0],
                                   EXPO_RST, GAIN_RST, BLACK_RST};
endpackage

// [isr_pix_if.sv]
`timescale 1ns/1ps
interface isr_pix_if;
   logic        inValid;
   logic [11:0] inSample;
   logic [1:0]  inTag;
   logic [11:0] black;
   logic [7:0]  gain;
   logic        compand;
   logic        outValid;
   logic [11:0] outData;
   logic [1:0]  outTag;
   modport chain (input inValid, inSample, inTag, black, gain, compand,
                  output outValid, outData, outTag);
   modport feed (output inValid, inSample, inTag, black, gain, compand,
                 input outValid, outData, outTag);
endinterface

// [isr_pixel_chain.sv]
`timescale 1ns/1ps
module isr_pixel_chain (
   input wire logic clk,
   input wire logic reset_n,
   isr_pix_if.chain px
);
   import isr_pkg::*;
   logic [11:0] stage;
   logic        stageValid;
   logic [1:0]  stageTag;
   logic        stageCmp;
   logic [11:0] outData;
   logic        outValid;
   logic [1:0]  outTag;

   // black level removal clamped at zero, then gain with saturation
   wire logic [11:0] corrected = (px.inSample > px.black) ? px.inSample - px.black : 12'h000;
   wire logic [19:0] product   = corrected * px.gain;
   wire logic [15:0] scaled    = product[19:GAIN_FRAC];
   wire logic [11:0] gained    = (scaled > {4'h0, PIX_MAX}) ? PIX_MAX : scaled[11:0];

   // stage one: corrected and gained sample
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage      <= 12'h000;
         stageValid <= 1'b0;
         stageTag   <= 2'h0;
         stageCmp   <= 1'b0;
      end else begin
         stage      <= gained;
         stageValid <= px.inValid;
         stageTag   <= px.inTag;
         stageCmp   <= px.compand;
      end
   end

   // four-segment compression curve, 12 bits in, 10 bits out
   wire logic [11:0] off1 = stage - SEG1;
   wire logic [11:0] off2 = stage - SEG2;
   wire logic [11:0] off3 = stage - SEG3;
   wire logic [9:0]  law  = (stage < SEG1) ? stage[9:0] :
                            (stage < SEG2) ? SEG1_BASE + {2'h0, off1[8:1]} :
                            (stage < SEG3) ? SEG2_BASE + {1'b0, off2[10:2]} :
                                             SEG3_BASE + {2'h0, off3[10:3]};
   wire logic [11:0] chainOut = stageCmp ? {2'h0, law} : stage;

   // stage two: output word
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         outData  <= 12'h000;
         outValid <= 1'b0;
         outTag   <= 2'h0;
      end else begin
         outData  <= chainOut;
         outValid <= stageValid;
         outTag   <= stageTag;
      end
   end

   assign px.outData  = outData;
   assign px.outValid = outValid;
   assign px.outTag   = outTag;

   a_compand_range: assert property (@(posedge clk) disable iff (!reset_n)
      (px.inValid && px.compand) |-> ##2 (px.outData < 12'h400))
      else $error("companded code exceeds ten bits");
   a_unity_gain: assert property (@(posedge clk) disable iff (!reset_n)
      (px.inValid && !px.compand && px.gain == GAIN_RST) |-> ##2 (px.outData == $past(corrected, 2)))
      else $error("unity gain output differs from corrected sample");
endmodule

// [isr_sensor_readout.sv]
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module isr_sensor_readout (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [2:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   input  wire logic [3:0]       avs_byteenable,
   output logic      [31:0]      avs_readdata,
   output logic                  avs_waitrequest,
   input  wire logic             pixelClk,
   input  wire isr_pkg::isr_pix_t adcSample,
   output isr_pkg::isr_row_t     rowResetAddr,
   output logic                  rowResetStrobe,
   output isr_pkg::isr_row_t     rowReadAddr,
   output logic                  rowReadStrobe,
   output logic                  pixelClockOut,
   output isr_pkg::isr_pix_t     parData,
   output logic                  frameValid,
   output logic                  lineValid,
   output isr_pkg::isr_pix_t     serPixel,
   output logic                  serValid,
   output logic                  highVcm
);
   import isr_pkg::*;
   logic [9:0]  ctrl;
   logic [10:0] expo;
   logic [7:0]  gain;
   logic [11:0] black;
   logic        rdValid;
   logic        busy;
   logic        dirty;
   logic        reqTgl;
   isr_cfg_s    cfgSent;
   logic [2:0]  ackSync;
   logic        ackSeen;
   logic [2:0]  frameSync;
   logic        frameSeen;
   logic [15:0] frameCount;
   logic [1:0]  linkRstSync;
   logic [2:0]  reqSync;
   logic        reqSeen;
   logic        ackTgl;
   logic        pendFlag;
   isr_cfg_s    cfgPend;
   isr_cfg_s    cfgLive;
   isr_state_e  state;
   isr_state_e  next_state;
   isr_row_t    col;
   isr_row_t    row;
   logic [1:0]  colPh;
   logic [1:0]  rowPh;
   logic        pclk;
   logic        frameTgl;

   isr_pix_if pix ();

   // avalon decode and byte-lane merge
   wire logic [31:0] laneMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   function automatic logic [31:0] merge(input logic [31:0] old);
      merge = (old & ~laneMask) | (avs_writedata & laneMask);
   endfunction
   wire logic [31:0] ctrlNew  = merge({22'h0, ctrl});
   wire logic [31:0] expoNew  = merge({21'h0, expo});
   wire logic [31:0] gainNew  = merge({24'h0, gain});
   wire logic [31:0] blackNew = merge({20'h0, black});
   wire logic wrCtrl  = avs_write && (avs_address == REG_CTRL);
   wire logic wrExpo  = avs_write && (avs_address == REG_EXPO);
   wire logic wrGain  = avs_write && (avs_address == REG_GAIN);
   wire logic wrBlack = avs_write && (avs_address == REG_BLACK);
   wire logic wrCfg   = wrCtrl || wrExpo || wrGain || wrBlack;
   wire logic [31:0] rdMux = (avs_address == REG_CTRL)   ? {22'h0, ctrl} :
                             (avs_address == REG_EXPO)   ? {21'h0, expo} :
                             (avs_address == REG_GAIN)   ? {24'h0, gain} :
                             (avs_address == REG_BLACK)  ? {20'h0, black} :
                             (avs_address == REG_STATUS) ? {frameCount, 15'h0, busy | dirty} : 32'h0;
   assign avs_waitrequest = avs_read && !rdValid;
   assign highVcm = ctrl[CTL_VCM];

   // software-visible configuration
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl  <= CTRL_RST;
         expo  <= EXPO_RST;
         gain  <= GAIN_RST;
         black <= BLACK_RST;
      end else begin
         if (wrCtrl) ctrl <= ctrlNew[9:0];
         if (wrExpo) expo <= expoNew[10:0];
         if (wrGain) gain <= gainNew[7:0];
         if (wrBlack) black <= blackNew[11:0];
      end
   end

   // reads answer after one wait state from a registered word
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdValid      <= 1'b0;
         avs_readdata <= 32'h0;
      end else begin
         rdValid <= avs_read && !rdValid;
         if (avs_read && !rdValid) avs_readdata <= rdMux;
      end
   end

   // hand a settled snapshot to the pixel side by toggle handshake
   wire logic launch = !busy && dirty;
   wire logic ackEv  = (ackSync[1] == ackSync[2]) && (ackSync[2] != ackSeen);
   wire isr_cfg_s cfgNow = {ctrl[CTL_MODE+:2], ctrl[CTL_CMP], ctrl[CTL_PAR], ctrl[CTL_EN], expo, gain, black};
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy    <= 1'b0;
         dirty   <= 1'b0;
         reqTgl  <= 1'b0;
         cfgSent <= CFG_RST;
         ackSync <= 3'h0;
         ackSeen <= 1'b0;
      end else begin
         ackSync <= {ackSync[1:0], ackTgl};
         dirty   <= wrCfg || (dirty && !launch); // a write beside a launch stays pending
         if (launch) begin
            cfgSent <= cfgNow;
            reqTgl  <= ~reqTgl;
            busy    <= 1'b1;
         end else if (ackEv) begin
            busy <= 1'b0;
         end
         if (ackEv) ackSeen <= ackSync[2];
      end
   end

   // frame counter fed by the frame-end toggle
   wire logic frameEv = (frameSync[1] == frameSync[2]) && (frameSync[2] != frameSeen);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         frameSync  <= 3'h0;
         frameSeen  <= 1'b0;
         frameCount <= 16'h0000;
      end else begin
         frameSync <= {frameSync[1:0], frameTgl};
         if (frameEv) frameSeen <= frameSync[2];
         if (frameEv) frameCount <= frameCount + 16'h0001;
      end
   end

   a_read_wait: assert property (@(posedge clk) disable iff (!reset_n)
      (avs_read && avs_waitrequest) |=> !avs_waitrequest)
      else $error("read not answered after one wait state");
   a_cfg_handoff: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(busy) |-> ##[1:40] !busy)
      else $error("configuration handoff not acknowledged");

   // pixel-side reset: asserted at once, released on the pll clock
   always_ff @(posedge pixelClk or negedge reset_n) begin
      if (!reset_n) linkRstSync <= 2'b00;
      else linkRstSync <= {linkRstSync[0], 1'b1};
   end
   wire logic linkRst_n = linkRstSync[1];

   // geometry of the live mode
   wire logic     sub3     = cfgLive.mode == MODE_SUB3;
   wire isr_row_t winW     = sub3 ? SUB3_WIN_W : FULL_W;
   wire isr_row_t winH     = sub3 ? SUB3_WIN_H : FULL_H;
   wire logic [1:0] subLast = (cfgLive.mode == MODE_FULL) ? 2'h0 : sub3 ? 2'h2 : 2'h1;
   wire isr_row_t lineLast = winW + HBLANK - 12'h001;
   wire isr_row_t rowLast  = winH + VBLANK - 12'h001;

   // frame edges and the boundary where settings switch
   wire logic stepEn     = cfgLive.parallel ? pclk : 1'b1;
   wire logic lineEnd    = stepEn && (col == lineLast);
   wire logic frameEnd   = (state == ST_RUN) && lineEnd && (row == rowLast);
   wire logic boundary   = (state == ST_IDLE) || frameEnd;
   wire logic applyNow   = pendFlag && boundary;
   wire logic nextEnable = applyNow ? cfgPend.enable : cfgLive.enable;
   wire logic reqEv      = (reqSync[1] == reqSync[2]) && (reqSync[2] != reqSeen);

   // take the snapshot, hold it until the next frame boundary
   always_ff @(posedge pixelClk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         reqSync  <= 3'h0;
         reqSeen  <= 1'b0;
         ackTgl   <= 1'b0;
         pendFlag <= 1'b0;
         cfgPend  <= CFG_RST;
         cfgLive  <= CFG_RST;
      end else begin
         reqSync  <= {reqSync[1:0], reqTgl};
         pendFlag <= reqEv || (pendFlag && !applyNow);
         if (reqEv) begin
            reqSeen <= reqSync[2];
            ackTgl  <= ~ackTgl;
            cfgPend <= cfgSent;
         end
         if (applyNow) cfgLive <= cfgPend;
      end
   end

   // run or stop only at a frame edge
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: if (cfgLive.enable) next_state = ST_RUN;
         ST_RUN:  if (frameEnd && !nextEnable) next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // column and row counters with subsampling phases
   always_ff @(posedge pixelClk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         state <= ST_IDLE;
         pclk  <= 1'b0;
         col   <= 12'h000;
         row   <= 12'h000;
         colPh <= 2'h0;
         rowPh <= 2'h0;
      end else begin
         state <= next_state;
         pclk  <= (next_state == ST_RUN) && cfgLive.parallel && !pclk;
         if (state != ST_RUN) begin
            col   <= 12'h000;
            row   <= 12'h000;
            colPh <= 2'h0;
            rowPh <= 2'h0;
         end else if (stepEn) begin
            col   <= lineEnd ? 12'h000 : col + 12'h001;
            colPh <= (lineEnd || colPh == subLast) ? 2'h0 : colPh + 2'h1;
            if (lineEnd) begin
               row   <= (row == rowLast) ? 12'h000 : row + 12'h001;
               rowPh <= (row == rowLast || rowPh == subLast) ? 2'h0 : rowPh + 2'h1;
            end
         end
      end
   end

   // sample feed into the correction chain
   wire logic rowInWin = (state == ST_RUN) && (row < winH);
   wire logic pixKeep  = rowInWin && stepEn && (col < winW) && (colPh == 2'h0) && (rowPh == 2'h0);
   assign pix.inValid  = pixKeep;
   assign pix.inSample = adcSample;
   assign pix.inTag    = {rowInWin, pixKeep};
   assign pix.black    = cfgLive.black;
   assign pix.gain     = cfgLive.gain;
   assign pix.compand  = cfgLive.compand;

   isr_pixel_chain uChain (
      .clk     (pixelClk),
      .reset_n (linkRst_n),
      .px      (pix.chain)
   );

   // reset pointer leads the read pointer by the exposure in rows
   wire isr_row_t expoRows = ({1'b0, cfgLive.expo} > rowLast) ? rowLast : {1'b0, cfgLive.expo};
   wire isr_row_t resetSum = row + expoRows;
   wire isr_row_t resetRow = (resetSum > rowLast) ? resetSum - rowLast - 12'h001 : resetSum;
   wire logic     rowStart = (state == ST_RUN) && stepEn && (col == 12'h000);
   always_ff @(posedge pixelClk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         rowReadStrobe  <= 1'b0;
         rowResetStrobe <= 1'b0;
         rowReadAddr    <= 12'h000;
         rowResetAddr   <= 12'h000;
      end else begin
         rowReadStrobe  <= rowStart && (row < winH);
         rowResetStrobe <= rowStart && (resetRow < winH);
         if (rowStart) rowReadAddr <= row;
         if (rowStart) rowResetAddr <= resetRow;
      end
   end

   // parallel words change as the output clock falls, serial words on each valid chain output
   always_ff @(posedge pixelClk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         parData    <= 12'h000;
         frameValid <= 1'b0;
         lineValid  <= 1'b0;
         serPixel   <= 12'h000;
         serValid   <= 1'b0;
         frameTgl   <= 1'b0;
      end else begin
         if (!cfgLive.parallel) begin
            frameValid <= 1'b0;
            lineValid  <= 1'b0;
         end else if (pclk) begin
            parData    <= pix.outData;
            frameValid <= pix.outTag[1];
            lineValid  <= pix.outTag[0];
         end
         serValid <= !cfgLive.parallel && pix.outValid;
         if (pix.outValid) serPixel <= pix.outData;
         if (frameEnd) frameTgl <= ~frameTgl;
      end
   end
   assign pixelClockOut = pclk;

   wire isr_row_t rowGap = (rowResetAddr >= rowReadAddr) ? rowResetAddr - rowReadAddr
                                                         : rowResetAddr + rowLast + 12'h001 - rowReadAddr;
   a_serial_rate: assert property (@(posedge pixelClk) disable iff (!linkRst_n)
      (state == ST_RUN && !cfgLive.parallel) |-> (stepEn && !pixelClockOut))
      else $error("serial feed not stepping every clock");
   a_half_rate: assert property (@(posedge pixelClk) disable iff (!linkRst_n)
      (cfgLive.parallel && stepEn) |=> !(stepEn && cfgLive.parallel))
      else $error("parallel port stepped on two clocks in a row");
   a_par_stable: assert property (@(posedge pixelClk) disable iff (!linkRst_n)
      $changed(parData) |-> $fell(pixelClockOut))
      else $error("parallel data changed away from falling output clock");
   a_line_in_frame: assert property (@(posedge pixelClk) disable iff (!linkRst_n)
      lineValid |-> frameValid)
      else $error("line valid outside frame valid");
   a_expo_gap: assert property (@(posedge pixelClk) disable iff (!linkRst_n)
      rowReadStrobe |-> (rowGap == expoRows))
      else $error("reset to read row gap differs from exposure");
   a_cfg_boundary: assert property (@(posedge pixelClk) disable iff (!linkRst_n)
      $changed(cfgLive) |-> $past(boundary))
      else $error("settings changed inside a frame");
   a_start_frame: assert property (@(posedge pixelClk) disable iff (!linkRst_n)
      (state == ST_IDLE && cfgLive.enable) |=> (state == ST_RUN && col == 12'h000 && row == 12'h000))
      else $error("enabled stream did not start a frame");
endmodule

// [isr_isp_model.sv]
`timescale 1ns/1ps
// image processor side of the serial feed: counts words per line, latches rows
module isr_isp_model (
   input  wire logic        pixelClk,
   input  wire logic        reset_n,
   input  wire logic [11:0] serPixel,
   input  wire logic        serValid,
   input  wire logic        rowReadStrobe,
   input  wire logic [11:0] rowReadAddr,
   input  wire logic        rowResetStrobe,
   input  wire logic [11:0] rowResetAddr,
   input  wire logic        parActive,
   output logic      [11:0] lineWords,
   output logic      [11:0] lastPixel,
   output logic      [11:0] readRow,
   output logic      [11:0] resetRow,
   output logic      [7:0]  lines,
   output logic             parSeen
);
   logic [11:0] wordCount;
   // a read strobe closes the count of the line before it
   always_ff @(posedge pixelClk or negedge reset_n) begin
      if (!reset_n) begin
         {lineWords, lastPixel, readRow, resetRow, wordCount} <= '0;
         lines <= 8'h0;
         parSeen <= 1'b0;
      end else begin
         if (rowReadStrobe) begin
            lineWords <= wordCount;
            wordCount <= {11'h0, serValid};
            readRow <= rowReadAddr;
            lines <= lines + 8'h1;
         end else if (serValid) begin
            wordCount <= wordCount + 12'h1;
         end
         if (serValid) lastPixel <= serPixel;
         if (rowResetStrobe) resetRow <= rowResetAddr;
         if (parActive) parSeen <= 1'b1;
      end
   end
endmodule

// [isr_sensor_readout_tb.sv]
`timescale 1ns/1ps
module isr_sensor_readout_tb;
   import isr_pkg::*;
   logic        clk, reset_n, pixelClk, avs_read, avs_write;
   logic [2:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, d;
   logic [3:0]  avs_byteenable;
   logic        avs_waitrequest, rowResetStrobe, rowReadStrobe, pixelClockOut;
   logic        frameValid, lineValid, serValid, highVcm, parSeen;
   logic [11:0] adcSample, rowResetAddr, rowReadAddr, parData, serPixel;
   logic [11:0] lineWords, lastPixel, readRow, resetRow;
   logic [7:0]  lines;
   int          n_fail = 0;
   int          comparisons = 0;

   isr_sensor_readout u_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pixelClk(pixelClk),
      .adcSample(adcSample), .rowResetAddr(rowResetAddr), .rowResetStrobe(rowResetStrobe),
      .rowReadAddr(rowReadAddr), .rowReadStrobe(rowReadStrobe), .pixelClockOut(pixelClockOut),
      .parData(parData), .frameValid(frameValid), .lineValid(lineValid), .serPixel(serPixel),
      .serValid(serValid), .highVcm(highVcm));
   isr_isp_model u_isp (.pixelClk(pixelClk), .reset_n(reset_n), .serPixel(serPixel), .serValid(serValid),
      .rowReadStrobe(rowReadStrobe), .rowReadAddr(rowReadAddr), .rowResetStrobe(rowResetStrobe),
      .rowResetAddr(rowResetAddr), .parActive(frameValid | lineValid | pixelClockOut),
      .lineWords(lineWords), .lastPixel(lastPixel), .readRow(readRow), .resetRow(resetRow),
      .lines(lines), .parSeen(parSeen));

   // core clock and an unrelated pixel clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      pixelClk = 1'b0;
      #3.3;
      forever #7.5 pixelClk = ~pixelClk;
   end

   task automatic fail_at(input string msg);
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) fail_at($sformatf("got %h expected %h", got, exp));
   endtask
   // bus cycle: request held until waitrequest is seen low at an edge
   task automatic av_xfer(input logic wr, input logic [2:0] a, input logic [31:0] wd, input logic [3:0] be);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      // a hung slave is caught by the watchdog, not here
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wait_lines(input logic [7:0] t);
      int n;
      n = 0;
      while (lines < t && n < 8000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 8000) fail_at("no line strobe");
   endtask
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      fail_at("watchdog");
      give_verdict;
   end

   // sequence of register accesses and stream checks
   initial begin
      {reset_n, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
      adcSample = 12'h1a8;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      chk({31'h0, highVcm}, 32'h0);
      av_xfer(1'b0, REG_CTRL, 32'h0, 4'hf);
      chk(d, 32'h1);
      av_xfer(1'b0, REG_EXPO, 32'h0, 4'hf);
      chk(d, 32'h200);
      av_xfer(1'b0, REG_GAIN, 32'h0, 4'hf);
      chk(d, 32'h10);
      av_xfer(1'b0, REG_BLACK, 32'h0, 4'hf);
      chk(d, 32'ha8);
      av_xfer(1'b0, REG_STATUS, 32'h0, 4'hf);
      chk(d, 32'h0);
      av_xfer(1'b1, 3'h5, 32'hffffffff, 4'hf);
      av_xfer(1'b0, 3'h5, 32'h0, 4'hf);
      chk(d, 32'h0);
      wait_lines(8'd2);
      chk({20'h0, lineWords}, 32'h900);
      chk({20'h0, readRow}, 32'h1);
      chk({20'h0, resetRow}, 32'h201);
      chk({20'h0, lastPixel}, 32'h100);
      chk({31'h0, parSeen}, 32'h0);
      av_xfer(1'b1, REG_GAIN, 32'h20, 4'hf);
      av_xfer(1'b1, REG_CTRL, 32'h211, 4'h3);
      av_xfer(1'b1, REG_BLACK, 32'hffffffff, 4'h1);
      av_xfer(1'b0, REG_CTRL, 32'h0, 4'hf);
      chk(d, 32'h211);
      chk({31'h0, highVcm}, 32'h1);
      av_xfer(1'b0, REG_BLACK, 32'h0, 4'hf);
      chk(d, 32'hff);
      av_xfer(1'b0, REG_STATUS, 32'h0, 4'hf);
      chk(d, 32'h1);
      wait_lines(8'd4);
      chk({20'h0, lineWords}, 32'h900);
      chk({20'h0, lastPixel}, 32'h100);
      give_verdict;
   end
endmodule
